// >>> hdl/gmc_global_mode_control.v
`timescale 1ns/10ps
`default_nettype none
`include "gmc_defs.vh"

// Overview of operation
// - Bit 15 selects T1 or E1
// - Standard change reloads matching framer defaults, no framer reset
// - Reload completes in about 34 line clocks
// - Bit 14 selects TDM or GCI timing
// - GCI only valid at 2.048 Mb/s rate
// - Rate bit low: 4.096 MHz, 2.048 Mb/s
// - Rate bit high: 16.384 MHz, 8.192 Mb/s
// - Soft reset rising edge resets framers T1
// - Soft reset acts like reset pin
// - Global space decoded at 9xx addresses
// - Global register same in T1 and E1
module gmc_global_mode_control
(
	input  wire                  mclk,          // 10 MHz system clock
	input  wire                  reset,         // Hardware reset pin
	input  wire                  ce,            // Clock enable
	input  wire [11:0]           addr,          // Register address
	input  wire [15:0]           dataIn,        // Write data from host
	input  wire                  csN,           // Chip select
	input  wire                  wrN,           // Write strobe
	input  wire                  rdN,           // Read strobe
	output reg  [15:0]           dataOut,       // Read data to host
	output reg                   dataOutEnN,    // Low while driving data
	output reg                   lineT1,        // Framers in T1 mode
	output reg                   gciTiming,     // GCI backplane timing
	output reg                   fastRate,      // 16.384 MHz / 8.192 Mb/s
	output reg                   framerReset,   // Reset to all framers
	output wire                  framerReload,  // Default reload running
	output reg                   reloadToT1     // Reload uses T1 defaults
);

	reg  [15:0]                  ctrl;
	reg                          wrIdle;
	wire                         globalHit;
	wire                         ctrlHit;
	wire                         wrStart;
	wire                         ctrlWrite;
	wire                         softReset;
	wire                         lineChange;
	wire                         softBusy;

	// Counts kept at full width, then cut to the timer width on purpose
	localparam [31:0]            SOFT_CYCLES   = `GMC_SOFT_RST_CYCLES;
	localparam [31:0]            RELOAD_CYCLES = `GMC_RELOAD_CYCLES;

	// ****************************************************************
	// Address decode and write strobe edge
	// ****************************************************************
	assign globalHit = addr[`GMC_GLOBAL_SEL_BIT] &
		addr[`GMC_GLOBAL_SEL_BIT2] &
		~addr[`GMC_GLOBAL_CLR_BIT] &
		~addr[`GMC_GLOBAL_CLR_BIT2];
	assign ctrlHit   = globalHit && (addr == `GMC_CTRL0_ADDR);
	// One write per strobe so a held strobe cannot repeat a reset
	assign wrStart   = ~csN & ~wrN & wrIdle;
	assign ctrlWrite = wrStart & ctrlHit;
	assign softReset = ctrlWrite & dataIn[`GMC_SOFT_RST_BIT] &
		~ctrl[`GMC_SOFT_RST_BIT];
	assign lineChange = ctrlWrite & ~softReset &
		(dataIn[`GMC_LINE_STD_BIT] != ctrl[`GMC_LINE_STD_BIT]);

	always @(posedge mclk)
	begin
		if (reset)
			wrIdle <= 1'b1;
		else if (ce)
			wrIdle <= csN | wrN;
	end

	// ****************************************************************
	// Global control register
	// ****************************************************************
	// Layout does not depend on the current line standard
	always @(posedge mclk)
	begin
		if (reset)
			ctrl <= `GMC_CTRL0_RESET;
		else if (ce)
		begin
			if (softReset)
				ctrl <= `GMC_CTRL0_RESET;
			else if (ctrlWrite)
				ctrl <= dataIn & `GMC_CTRL0_MASK;
		end
	end

	// ****************************************************************
	// Mode outputs
	// ****************************************************************
	always @(posedge mclk)
	begin
		if (reset)
		begin
			lineT1    <= 1'b1;
			gciTiming <= 1'b0;
			fastRate  <= 1'b0;
		end
		else if (ce)
		begin
			lineT1    <= ctrl[`GMC_LINE_STD_BIT];
			// GCI is held off while the fast rate is selected
			gciTiming <= ctrl[`GMC_BACKPLANE_BIT] &
				~ctrl[`GMC_CLK_RATE_BIT];
			fastRate  <= ctrl[`GMC_CLK_RATE_BIT];
		end
	end

	// ****************************************************************
	// Framer reset and default reload
	// ****************************************************************
	gmc_pulse_timer
	#(
		.WIDTH (`GMC_TIMER_W),
		.COUNT (SOFT_CYCLES[`GMC_TIMER_W-1:0])
	)
	softTimer
	(
		.mclk  (mclk),
		.reset (reset),
		.ce    (ce),
		.start (softReset),
		.busy  (softBusy)
	);

	gmc_pulse_timer
	#(
		.WIDTH (`GMC_TIMER_W),
		.COUNT (RELOAD_CYCLES[`GMC_TIMER_W-1:0])
	)
	reloadTimer
	(
		.mclk  (mclk),
		.reset (reset | softReset),
		.ce    (ce),
		.start (lineChange),
		.busy  (framerReload)
	);

	always @(posedge mclk)
	begin
		if (reset)
		begin
			framerReset <= 1'b1;
			reloadToT1  <= 1'b1;
		end
		else if (ce)
		begin
			framerReset <= softReset | softBusy;
			if (softReset)
				reloadToT1 <= 1'b1;
			else if (lineChange)
				reloadToT1 <= dataIn[`GMC_LINE_STD_BIT];
		end
	end

	// ****************************************************************
	// Read path
	// ****************************************************************
	always @(posedge mclk)
	begin
		if (reset)
		begin
			dataOut    <= `GMC_ZERO_WORD;
			dataOutEnN <= 1'b1;
		end
		else if (ce)
		begin
			if (~csN & ~rdN & ctrlHit)
			begin
				dataOut    <= ctrl;
				dataOutEnN <= 1'b0;
			end
			else if (~csN & ~rdN & globalHit)
			begin
				dataOut    <= `GMC_ZERO_WORD;
				dataOutEnN <= 1'b0;
			end
			else
			begin
				dataOut    <= `GMC_ZERO_WORD;
				dataOutEnN <= 1'b1;
			end
		end
	end

endmodule // gmc_global_mode_control

`default_nettype wire

// >>> hdl/gmc_defs.vh
`ifndef GMC_DEFS_VH
`define GMC_DEFS_VH

// ****************************************************************
// Register map
// ****************************************************************
`define GMC_ADDR_W          12
`define GMC_DATA_W          16
`define GMC_CTRL0_ADDR      12'h900
`define GMC_GLOBAL_SEL_BIT  11
`define GMC_GLOBAL_SEL_BIT2 8
`define GMC_GLOBAL_CLR_BIT  10
`define GMC_GLOBAL_CLR_BIT2 9

// ****************************************************************
// Control field layout and reset value
// ****************************************************************
`define GMC_LINE_STD_BIT    15
`define GMC_BACKPLANE_BIT   14
`define GMC_CLK_RATE_BIT    4
`define GMC_SOFT_RST_BIT    0
`define GMC_CTRL0_MASK      16'hC011
`define GMC_CTRL0_RESET     16'h8000
`define GMC_ZERO_WORD       16'h0000

// ****************************************************************
// Timing
// ****************************************************************
`define GMC_MCLK_KHZ        10000
`define GMC_LINE_CLK_KHZ    1544
`define GMC_RELOAD_LINE_CYC 34
`define GMC_RELOAD_CYCLES   ((`GMC_RELOAD_LINE_CYC * `GMC_MCLK_KHZ + `GMC_LINE_CLK_KHZ - 1) / `GMC_LINE_CLK_KHZ)
`define GMC_SOFT_RST_CYCLES 4
`define GMC_TIMER_W         9
`define GMC_TIMER_ONE       9'h001
`define GMC_TIMER_ZERO      9'h000

`endif

// >>> hdl/gmc_pulse_timer.v
`timescale 1ns/10ps
`default_nettype none
`include "gmc_defs.vh"

module gmc_pulse_timer
#(
	parameter                    WIDTH = `GMC_TIMER_W,
	parameter [WIDTH-1:0]        COUNT = `GMC_SOFT_RST_CYCLES
)
(
	input  wire                  mclk,   // System clock
	input  wire                  reset,  // Synchronous reset
	input  wire                  ce,     // Clock enable
	input  wire                  start,  // Restart the interval
	output reg                   busy    // High for COUNT cycles
);

	reg  [WIDTH-1:0]             remain;

	// ****************************************************************
	// Down counter; a new start restarts the interval
	// ****************************************************************
	always @(posedge mclk)
	begin
		if (reset)
		begin
			remain <= {WIDTH{1'b0}};
			busy   <= 1'b0;
		end
		else if (ce)
		begin
			if (start)
			begin
				remain <= COUNT;
				busy   <= 1'b1;
			end
			else if (remain != {WIDTH{1'b0}})
			begin
				remain <= remain - {{(WIDTH-1){1'b0}}, 1'b1};
				busy   <= (remain != {{(WIDTH-1){1'b0}}, 1'b1});
			end
			else
			begin
				busy   <= 1'b0;
			end
		end
	end

endmodule // gmc_pulse_timer

`default_nettype wire

// >>> verification/gmc_props.sv
`timescale 1ns/10ps
`default_nettype none
// ****
// Checker
// ****
module gmc_props
(
	input wire logic        mclk,         // Clock
	input wire logic        reset,        // Reset
	input wire logic        ce,           // Enable
	input wire logic [11:0] addr,         // Address
	input wire logic [15:0] dataIn,       // Write data
	input wire logic        csN,          // Select
	input wire logic        wrN,          // Write
	input wire logic        rdN,          // Read
	input wire logic [15:0] dataOut,      // Read data
	input wire logic        dataOutEnN,   // Drive
	input wire logic        lineT1,       // T1
	input wire logic        gciTiming,    // GCI
	input wire logic        fastRate,     // Rate
	input wire logic        framerReset,  // Reset out
	input wire logic        framerReload, // Reload
	input wire logic        reloadToT1    // Set
);
default clocking @(posedge mclk); endclocking
default disable iff (reset || !ce);
sequence s_wr;
	!csN && !wrN && $past(csN || wrN) && addr == 12'h900;
endsequence
// Mode outputs trail the register by one cycle
property p_mode;
	s_wr ##0 !dataIn[0] |=> ##1 (lineT1 == $past(dataIn[15], 2) &&
	fastRate == $past(dataIn[4], 2) &&
	gciTiming == ($past(dataIn[14], 2) && !$past(dataIn[4], 2)));
endproperty
property p_std;
	$changed(lineT1) && !framerReset |-> framerReload &&
	reloadToT1 == lineT1;
endproperty
property p_reload;
	$rose(framerReload) |-> ##220 framerReload ##1 !framerReload;
endproperty
property p_soft;
	s_wr ##0 dataIn[0] |=> (framerReset && reloadToT1 && !framerReload)[*5]
	##1 !framerReset;
endproperty
property p_hold;
	s_wr ##1 (!csN && !wrN)[*7] |-> !framerReset;
endproperty
property p_gci;
	gciTiming |-> !fastRate;
endproperty
property p_en;
	csN || rdN || addr[11:8] != 4'h9 |=> dataOutEnN;
endproperty
property p_rd;
	!csN && !rdN && addr[11:8] == 4'h9 |=> !dataOutEnN &&
	dataOut[13:5] == 9'h000 && dataOut[3:0] == 4'h0;
endproperty
a_mode: assert property (p_mode) else $error("mode out");
a_std: assert property (p_std) else $error("no reload");
a_reload: assert property (p_reload) else $error("reload len");
a_soft: assert property (p_soft) else $error("soft reset");
a_hold: assert property (p_hold) else $error("reset repeat");
a_gci: assert property (p_gci) else $error("gci fast");
a_en: assert property (p_en) else $error("stray drive");
a_rd: assert property (p_rd) else $error("read word");
c_soft: cover property (s_wr ##0 dataIn[0]);
c_rel: cover property ($rose(framerReload));
c_rd: cover property (!dataOutEnN);
endmodule // gmc_props
bind gmc_global_mode_control gmc_props chk_u (.*);
`default_nettype wire

// >>> verification/gmc_host_model.sv
`timescale 1ns/10ps
`default_nettype none
// ****
// Host
// ****
module gmc_host_model
(
	input wire logic        mclk,       // Clock
	input wire logic [15:0] dataOut,    // Read data
	input wire logic        dataOutEnN, // Drive
	output logic     [11:0] addr,       // Address
	output logic     [15:0] dataIn,     // Write data
	output logic            csN,        // Select
	output logic            wrN,        // Write
	output logic            rdN         // Read
);
logic std = 1'b1;
logic pend = 1'b0;
initial {csN, wrN, rdN, addr, dataIn} = {3'h7, 28'h0};
task automatic wr(input logic [11:0] a, input logic [15:0] d, input int n);
	if (pend)
		repeat (1250) @(posedge mclk);
	pend = 1'b0;
	@(posedge mclk) #1;
	{csN, wrN, addr, dataIn} = {2'h0, a, d};
	repeat (n) @(posedge mclk);
	#1 {csN, wrN, addr, dataIn} = {2'h3, ~a, ~d};
	if (a == 12'h900 && d[0])
		std = 1'b1;
	else if (a == 12'h900 && d[15] != std)
		{pend, std} = {1'b1, d[15]};
endtask
task automatic rd(input logic [11:0] a, output logic [16:0] r);
	@(posedge mclk) #1;
	{csN, rdN, addr} = {2'h0, a};
	@(posedge mclk) #1;
	r = {dataOutEnN, dataOut};
	{csN, rdN, addr} = {2'h3, ~a};
endtask
endmodule // gmc_host_model
`default_nettype wire

// >>> verification/tb_global_mode_control.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin testsRun++; if ((g) !== (e)) begin failures++; \
$display("unexpected %s exp %h got %h", n, e, g); end end
// ****
// Bench
// ****
module tb_global_mode_control;
logic mclk = 1'b0;
logic reset = 1'b1;
logic ce = 1'b1;
wire [11:0] addr;
wire [15:0] dataIn, dataOut;
wire csN, wrN, rdN, dataOutEnN, lineT1, gciTiming, fastRate;
wire framerReset, framerReload, reloadToT1;
int failures = 0;
int testsRun = 0;
logic [11:0] ad[4] = '{12'h91F, 12'h901, 12'h100, 12'hB00};
logic [16:0] ex[4] = '{17'h00000, 17'h00000, 17'h10000, 17'h10000};
gmc_global_mode_control dut_u (.*);
gmc_host_model host_u (.*);
initial forever #50 mclk = ~mclk;
function automatic logic [16:0] expCtrl(input logic [15:0] v);
	return {1'b0, v & 16'hC011};
endfunction
function automatic logic [3:0] expModes(input logic [15:0] v);
	return {v[15], v[14] & ~v[4], v[4], 1'b0};
endfunction
task endOfTest;
	$display("checks %0d mismatches %0d", testsRun, failures);
	if (failures == 0 && testsRun > 0)
		$display("All checks passed");
	else
		$display("Checks failed");
	$finish;
endtask
initial
begin
	repeat (20000) @(posedge mclk);
	failures++;
	endOfTest;
end
initial
begin
	logic [16:0] r;
	logic [15:0] d;
	logic s;
	logic [3:0] m;
	d = $urandom(9);
	s = 1'b1;
	repeat (10) @(posedge mclk);
	#1 reset = 1'b0;
	host_u.rd(12'h900, r);
	`CHK("ctrl", 17'h08000, r)
	`CHK("t1", 2'h3, {lineT1, reloadToT1})
	$display("test reset done");
	repeat (6)
	begin
		d = $urandom & 16'hFFFE;
		if (d[4])
			d[14] = 1'b0;
		host_u.wr(12'h900, d, 1);
		@(posedge mclk) #1;
		`CHK("reload", d[15] != s, framerReload)
		`CHK("set", d[15], reloadToT1)
		s = d[15];
		m = {lineT1, gciTiming, fastRate, framerReset};
		`CHK("modes", expModes(d), m)
		host_u.rd(12'h900, r);
		`CHK("ctrl", expCtrl(d), r)
	end
	$display("test modes done");
	foreach (ad[i])
	begin
		host_u.rd(ad[i], r);
		`CHK("decode", ex[i], r)
	end
	host_u.wr(12'h901, ~d, 1);
	host_u.rd(12'h900, r);
	`CHK("ignored", expCtrl(d), r)
	$display("test decode done");
	host_u.wr(12'h900, 16'h0011, 8);
	`CHK("soft", 3'h4, {lineT1, fastRate, framerReset})
	host_u.rd(12'h900, r);
	`CHK("ctrl", 17'h08000, r)
	$display("test soft reset done");
	ce = 1'b0;
	host_u.wr(12'h900, 16'h8010, 2);
	@(posedge mclk) #1;
	ce = 1'b1;
	host_u.rd(12'h900, r);
	`CHK("freeze", 18'h08000, {fastRate, r})
	$display("test freeze done");
	endOfTest;
end
endmodule // tb_global_mode_control
`default_nettype wire
